/* inc/rx_cdr_pkg.sv */
// Shared constants and types for the receive clock and data recovery block
package rx_cdr_pkg;

    // ------------------------------------------------------------
    // Oversampling and voting positions
    // ------------------------------------------------------------
    localparam logic [4:0] SPB_NORMAL        = 5'h10;
    localparam logic [4:0] SPB_DOUBLE        = 5'h08;
    localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
    localparam logic [4:0] VOTE_LAST_NORMAL  = 5'h0a;
    localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
    localparam logic [4:0] VOTE_LAST_DOUBLE  = 5'h06;
    localparam logic [4:0] SAMPLE_FIRST      = 5'h01;

    // ------------------------------------------------------------
    // Frame size and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] BITS_MIN       = 4'h5;
    localparam logic [3:0] BITS_MAX       = 4'ha;
    localparam int         FRAME_W        = 10;
    localparam logic [9:0] FRAME_RST      = 10'h000;
    localparam int         DIV_W_DEFAULT  = 12;

    // ------------------------------------------------------------
    // Receiver phase
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_DATA  = 2'b10,
        ST_STOP  = 2'b11
    } rx_phase_t;

endpackage

/* rtl/baud_tick_gen.sv */
// Oversampling tick generator driven by the baud divider value
`timescale 1ns/1ps
module baud_tick_gen
    import rx_cdr_pkg::*;
#(
    parameter int DIV_W = DIV_W_DEFAULT
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic [DIV_W-1:0] baud_divider_value,
    output logic                  tick
);

    if (DIV_W < 1) begin : g_bad_width
        $error("baud_tick_gen: DIV_W must be at least 1");
    end

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } tick_state_t;

    tick_state_t q;
    tick_state_t d;

    // ------------------------------------------------------------
    // Down counter, one tick every divider+1 clocks
    // ------------------------------------------------------------
    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (q.cnt == '0) begin
            d.cnt  = baud_divider_value;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // The reload value is judged from the counter, since the divider input may move later
    tick_period_a: assert property (q.tick && (q.cnt != '0) |=> !q.tick) // see RULE_15
        else $error("tick repeated with nonzero divider");

endmodule

/* rtl/async_rx_cdr.sv */
// Receive clock and data recovery for an asynchronous serial line
`timescale 1ns/1ps
// Function
// [RULE_01] Oversample 16x normal, 8x double speed
// [RULE_02] Double speed select one picks 8x
// [RULE_03] Idle-to-low transition starts start detection
// [RULE_04] Start votes: samples 8,9,10 or 4,5,6
// [RULE_05] Majority high start is noise, resume search
// [RULE_06] Resynchronise bit timing on every start
// [RULE_07] Per-bit state counter, 16 or 8 states
// [RULE_08] Bit value is majority of centre samples
// [RULE_09] Recover data, parity, first stop only
// [RULE_10] Stop voted zero sets framing error
// [RULE_11] New edge accepted right after stop vote
// [RULE_12] Five to ten data plus parity bits
// [RULE_13] Double speed halves prescale, doubles bitrate
// [RULE_14] Two-stage synchroniser on serial input
// [RULE_15] Sampling advances only on oversampling tick
module async_rx_cdr
    import rx_cdr_pkg::*;
#(
    parameter int DIV_W = DIV_W_DEFAULT
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             rx_serial,
    input  wire logic             double_speed_select,
    input  wire logic [DIV_W-1:0] baud_divider_value,
    input  wire logic [3:0]       frame_bits,
    output logic [FRAME_W-1:0]    frame_data,
    output logic                  frame_valid,
    output logic                  framing_error_flag,
    output logic                  start_rejected
);

    if (DIV_W < 1) begin : g_bad_width
        $error("async_rx_cdr: DIV_W must be at least 1");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    function automatic logic [4:0] spb(input logic ds);
        spb = ds ? SPB_DOUBLE : SPB_NORMAL; // see RULE_13
    endfunction

    function automatic logic in_vote(input logic [4:0] c, input logic ds);
        if (ds) begin
            in_vote = (c >= VOTE_FIRST_DOUBLE) && (c <= VOTE_LAST_DOUBLE);
        end else begin
            in_vote = (c >= VOTE_FIRST_NORMAL) && (c <= VOTE_LAST_NORMAL);
        end
    endfunction

    function automatic logic vote_end(input logic [4:0] c, input logic ds);
        vote_end = c == (ds ? VOTE_LAST_DOUBLE : VOTE_LAST_NORMAL);
    endfunction

    // Out-of-range sizes are clamped rather than left undefined
    function automatic logic [3:0] clamp_bits(input logic [3:0] b);
        if (b < BITS_MIN) begin
            clamp_bits = BITS_MIN;
        end else if (b > BITS_MAX) begin
            clamp_bits = BITS_MAX;
        end else begin
            clamp_bits = b;
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic               meta;
        logic               sync;
        logic               last_s;
        rx_phase_t          st;
        logic [4:0]         cnt;
        logic               ds;
        logic [3:0]         nbits;
        logic [3:0]         bit_idx;
        logic [2:0]         votes;
        logic [FRAME_W-1:0] shift;
        logic [FRAME_W-1:0] data;
        logic               valid;
        logic               fe;
        logic               rej;
    } rx_state_t;

    rx_state_t q;
    rx_state_t d;
    logic      tick;
    logic      bit_v;

    baud_tick_gen #(
        .DIV_W (DIV_W)
    ) u_tick (
        .sys_clk            (sys_clk),
        .sys_rst            (sys_rst),
        .baud_divider_value (baud_divider_value),
        .tick               (tick)
    ); // see RULE_15

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d       = q;
        bit_v   = maj3({q.votes[1:0], q.sync}); // see RULE_08
        d.valid = 1'b0;
        d.rej   = 1'b0;
        d.meta  = rx_serial; // see RULE_14
        d.sync  = q.meta; // see RULE_14
        if (tick) begin // see RULE_15
            d.last_s = q.sync;
            if (q.st == ST_IDLE) begin
                if (q.last_s && !q.sync) begin // see RULE_03
                    d.st      = ST_START;
                    d.cnt     = SAMPLE_FIRST; // see RULE_06
                    d.ds      = double_speed_select; // see RULE_02
                    d.nbits   = clamp_bits(frame_bits); // see RULE_12
                    d.bit_idx = 4'h0;
                    d.shift   = FRAME_RST;
                    d.votes   = 3'h0;
                end
            end else begin
                if (in_vote(q.cnt, q.ds)) begin // see RULE_04
                    d.votes = {q.votes[1:0], q.sync};
                end
                // Bit length follows the prescale chosen at the start edge
                if (q.cnt == spb(q.ds)) begin // see RULE_07
                    d.cnt = SAMPLE_FIRST;
                end else begin
                    d.cnt = q.cnt + 5'h01; // see RULE_01
                end
                case (q.st)
                    ST_START: begin
                        if (vote_end(q.cnt, q.ds) && bit_v) begin // see RULE_05
                            d.st  = ST_IDLE;
                            d.rej = 1'b1;
                        end else if (q.cnt == spb(q.ds)) begin
                            d.st = ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (vote_end(q.cnt, q.ds)) begin
                            d.shift[q.bit_idx] = bit_v; // see RULE_09
                            d.bit_idx          = q.bit_idx + 4'h1;
                        end
                        if ((q.cnt == spb(q.ds)) && (q.bit_idx == q.nbits)) begin
                            d.st = ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        // Only the first stop bit is looked at
                        if (vote_end(q.cnt, q.ds)) begin // see RULE_09
                            d.data  = q.shift;
                            d.fe    = !bit_v; // see RULE_10
                            d.valid = 1'b1;
                            d.st    = ST_IDLE; // see RULE_11
                        end
                    end
                    default: begin
                        d.st = ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q        <= '0;
            q.meta   <= 1'b1;
            q.sync   <= 1'b1;
            q.last_s <= 1'b1;
            q.st     <= ST_IDLE;
            q.data   <= FRAME_RST;
            q.shift  <= FRAME_RST;
        end else begin
            q <= d;
        end
    end

    assign frame_data         = q.data;
    assign frame_valid        = q.valid;
    assign framing_error_flag = q.fe;
    assign start_rejected     = q.rej;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_edge;
        (q.st == ST_IDLE) && tick && q.last_s && !q.sync;
    endsequence

    sequence s_started;
        (q.st == ST_START) && (q.cnt == SAMPLE_FIRST);
    endsequence

    sync_delay_a: assert property (##2 (q.sync == $past(rx_serial, 2))) // see RULE_14
        else $error("synchroniser depth wrong");
    no_tick_hold_a: assert property (!tick |=> $stable(q.cnt) && $stable(q.st)) // see RULE_15
        else $error("state moved without tick");
    start_detect_a: assert property (s_edge |=> s_started) // see RULE_03
        else $error("start edge not taken");
    reject_idle_a: assert property (q.rej |-> (q.st == ST_IDLE) && $past(q.st) == ST_START) // see RULE_05
        else $error("reject not from start phase");
    count_range_a: assert property ((q.st != ST_IDLE) |-> (q.cnt >= SAMPLE_FIRST)
        && (q.cnt <= spb(q.ds))) // see RULE_07
        else $error("sample counter out of range");
    bit_wrap_a: assert property (tick && (q.st != ST_IDLE) && !q.rej
        && (q.cnt == spb(q.ds)) && (q.st != ST_START || !vote_end(q.cnt, q.ds))
        |=> q.cnt == SAMPLE_FIRST) // see RULE_01
        else $error("bit counter did not wrap");
    stop_fe_a: assert property (q.valid |-> q.fe == !$past(bit_v)) // see RULE_10
        else $error("framing error does not match stop vote");
    frame_end_a: assert property (q.valid |-> (q.st == ST_IDLE) && ($past(q.st) == ST_STOP)
        ##1 !q.valid) // see RULE_11
        else $error("frame end not one idle pulse");
    data_count_a: assert property ((q.st == ST_STOP) |-> q.bit_idx == q.nbits) // see RULE_12
        else $error("wrong number of data bits");

endmodule

/* test/serial_tx_model.sv */
// Behavioural remote transmitter that drives the serial receive line
`timescale 1ns/1ps
module serial_tx_model (
    input  wire logic sys_clk,
    output logic      rx_line
);
    // Line idles high between frames
    initial rx_line = 1'b1;

    // ------------------------------------------------------------
    // Line driving
    // ------------------------------------------------------------
    // Called at a falling edge; holds a level for whole sample periods
    task automatic hold(input logic lvl, input int samples, input int per);
        rx_line = lvl;
        repeat (samples * per) @(negedge sys_clk);
    endtask

    // One frame, first bit LSB; a short stop allows an early next start
    task automatic send(input logic [9:0] data, input int nbits, input logic stop_val,
                        input int spb, input int per, input int stop_len);
        hold(1'b0, spb, per);
        for (int i = 0; i < nbits; i++) begin
            hold(data[i], spb, per);
        end
        hold(stop_val, stop_len, per);
    endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the receive clock and data recovery block
`timescale 1ns/1ps
module testbench;
    import rx_cdr_pkg::*;

    logic               sys_clk;
    logic               sys_rst;
    logic               double_speed_select;
    logic [11:0]        baud_divider_value;
    logic [3:0]         frame_bits;
    wire logic          rx_serial;
    logic [FRAME_W-1:0] frame_data;
    logic               frame_valid;
    logic               framing_error_flag;
    logic               start_rejected;
    int                 err_count;
    int                 check_count;
    logic [11:0]        exp_q[$];

    serial_tx_model i_serial_tx_model (
        .sys_clk (sys_clk),
        .rx_line (rx_serial)
    );

    async_rx_cdr i_async_rx_cdr (
        .sys_clk             (sys_clk),
        .sys_rst             (sys_rst),
        .rx_serial           (rx_serial),
        .double_speed_select (double_speed_select),
        .baud_divider_value  (baud_divider_value),
        .frame_bits          (frame_bits),
        .frame_data          (frame_data),
        .frame_valid         (frame_valid),
        .framing_error_flag  (framing_error_flag),
        .start_rejected      (start_rejected)
    );

    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Checking and verdict
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Stimulus helpers
    // ------------------------------------------------------------
    // Expected note is {rejected, framing error, data}
    task automatic frame(input logic [9:0] d, input int n, input logic stop, input logic dbl,
                         input int stop_len, input int idle);
        int per;
        per = int'(baud_divider_value) + 1;
        double_speed_select = dbl;
        frame_bits = 4'(n);
        exp_q.push_back({1'b0, ~stop, d & ((10'h1 << n) - 10'h1)});
        i_serial_tx_model.send(d, n, stop, dbl ? 8 : 16, per, stop_len);
        i_serial_tx_model.hold(1'b1, idle, per);
    endtask

    // Low pulse too short to win the start vote
    task automatic glitch(input logic dbl);
        int per;
        per = int'(baud_divider_value) + 1;
        double_speed_select = dbl;
        exp_q.push_back(12'h800);
        i_serial_tx_model.hold(1'b0, dbl ? 2 : 3, per);
        i_serial_tx_model.hold(1'b1, 20, per);
    endtask

    // Outputs are read mid-cycle, well clear of the launching edge
    always @(negedge sys_clk) begin
        if (sys_rst === 1'b0 && (frame_valid === 1'b1 || start_rejected === 1'b1)) begin
            if (exp_q.size() == 0)
                check("unexpected", 12'h000, 12'hfff);
            else
                check("result", start_rejected ? 12'h800 : {2'b00 | framing_error_flag,
                      frame_data}, exp_q.pop_front());
        end
    end

    initial begin
        #(60000 * 100);
        err_count++;
        close_out();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic dbl;
        sys_rst = 1'b1;
        double_speed_select = 1'b0;
        baud_divider_value = 12'h001;
        frame_bits = 4'h8;
        err_count = 0;
        check_count = 0;
        void'($urandom(54));
        repeat (8) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        for (int m = 0; m < 2; m++) begin
            for (int n = 5; n <= 10; n++) begin
                frame(10'($urandom), n, 1'b1, m[0], m ? 8 : 16, 4);
            end
        end
        frame(10'h155, 8, 1'b0, 1'b0, 16, 20);
        frame(10'h0aa, 7, 1'b0, 1'b1, 8, 20);
        glitch(1'b0);
        glitch(1'b1);
        // Back-to-back frames with the earliest legal next start
        for (int k = 0; k < 12; k++) begin
            // Divider moves only in idle time; a stale tick phase would skew the votes
            if (k % 4 == 0) begin
                baud_divider_value = 12'($urandom_range(3));
                i_serial_tx_model.hold(1'b1, 16, int'(baud_divider_value) + 1);
            end
            dbl = 1'($urandom_range(1));
            frame(10'($urandom), $urandom_range(10, 5), 1'b1, dbl, dbl ? 7 : 11, 0);
        end
        i_serial_tx_model.hold(1'b1, 40, 4);
        check("pending", 12'(exp_q.size()), 12'h000);
        close_out();
    end
endmodule
